// file: core/alarm_pkg.sv
// Types shared by the insulation alarm evaluator
package alarm_pkg;

  typedef enum logic [1:0] {
    ALARM_IDLE   = 2'b00,
    ALARM_COUNT  = 2'b01,
    ALARM_ACTIVE = 2'b10
  } alarm_state_t;

  typedef enum logic [1:0] {
    ADAPT_NONE    = 2'b00,
    ADAPT_VOLTAGE = 2'b01,
    ADAPT_GROUND  = 2'b10
  } adaptor_t;

endpackage

// file: core/insulation_alarm_evaluator.sv
// Insulation alarm evaluator with AHB-Lite register slave
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`include "insulation_alarm_params.svh"

// Functional notes
// RL1: Thresholds are compared against the compensated resistance, never the raw one.
// RL2: Grounding compensation defaults off; when on, adds the set grounding resistance.
// RL3: Winding resistance accepts 0 to 50 kilohm; used only with ground adaptor.
// RL4: Total winding resistance is per-transformer value times count of 0, 1 or 3.
// RL5: Main threshold is clamped to its range and resets to 1 kilohm.
// RL6: Early threshold is 1 kilohm to 1 megohm or off; off by default.
// RL7: After power-up the stored main and early thresholds are restored.
// RL8: Software keeps the early threshold strictly above the main threshold.
// RL9: Dropping below threshold raises the alarm at once, or starts its countdown.
// RL10: An active alarm clears only above 1.2 times its threshold; the early alarm also clears when its threshold is set off.
// RL11: A fault is reported only after persisting through the whole delay.
// RL12: Each delay is settable from 0 s to 120 minutes, default 0 s.
// RL13: With the early threshold off, the early delay is ignored.
// RL14: Injection and ground wire breaks are flagged only when detection is on.
// RL15: Voltage adaptor link breaks are always detected, regardless of detection setting.
// RL16: A disconnected injection raises its status and lights the product status LED.
// RL17: Grounding compensation is meant only for plain resistive neutral grounding.
// RL18: Recovery before the delay expires abandons the countdown without an alarm.
// RL19: Ground adaptor option exists; fault location is unavailable while selected.
module insulation_alarm_evaluator #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  wire logic [`RES_W-1:0]   meas_value,
  input  wire logic                meas_valid,
  input  wire logic                stored_valid,
  input  wire logic [`RES_W-1:0]   stored_main_thr,
  input  wire logic [`RES_W-1:0]   stored_early_thr,
  output logic                     thr_store_we,
  output logic [`RES_W-1:0]        thr_store_main,
  output logic [`RES_W-1:0]        thr_store_early,
  input  wire logic                inj_open_pin,
  input  wire logic                gnd_open_pin,
  input  wire logic                adaptor_link_pin,
  output logic                     main_alarm,
  output logic                     early_alarm,
  output logic                     disconnected_injection,
  output logic                     adaptor_link_broken,
  output logic                     product_status_led,
  output logic                     fault_location_ok,
  output logic                     irq
);

  localparam int unsigned CYC_W = $clog2(TICK_CYCLES + 1);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [`RES_W-1:0] clamp_res(
    input logic [31:0]        v,
    input logic [`RES_W-1:0]  lo,
    input logic [`RES_W-1:0]  hi
  );
    if (v < {8'h00, lo}) begin
      clamp_res = lo;
    end else if (v > {8'h00, hi}) begin
      clamp_res = hi;
    end else begin
      clamp_res = v[`RES_W-1:0];
    end
  endfunction

  function automatic logic [`DELAY_W-1:0] clamp_delay(input logic [31:0] v);
    if (v > {19'h00000, `DELAY_MAX_S}) begin
      clamp_delay = `DELAY_MAX_S;
    end else begin
      clamp_delay = v[`DELAY_W-1:0];
    end
  endfunction

  // Exact 1.2x test without a divider: 5*r > 6*t
  function automatic logic above_hyst(
    input logic [`RES_W-1:0] r,
    input logic [`RES_W-1:0] t
  );
    above_hyst = ({3'b000, r} * 27'h0000005) > ({3'b000, t} * 27'h0000006);
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic                     comp_en_q;
  logic                     disc_en_q;
  alarm_pkg::adaptor_t      adaptor_q;
  logic [1:0]               xfmr_count_q;
  logic [`RES_W-1:0]        ground_res_q;
  logic [`RES_W-1:0]        winding_res_q;
  logic [`RES_W-1:0]        main_thr_q;
  logic [`RES_W-1:0]        early_thr_q;
  logic [`DELAY_W-1:0]      main_delay_q;
  logic [`DELAY_W-1:0]      early_delay_q;
  logic [`IRQ_W-1:0]        irq_status_q;
  logic [`IRQ_W-1:0]        irq_mask_q;
  logic                     restore_pending_q;

  // AHB data-phase bookkeeping
  logic                     wr_pend_q;
  logic                     rd_pend_q;
  logic                     rd_done_q;
  logic [`ADDR_W-1:0]       addr_q;
  logic [31:0]              hrdata_q;
  logic                     addr_accept;
  logic                     wr_fire;
  logic [31:0]              rd_mux;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  // Reads take one wait state so a write just before is visible
  assign hreadyout   = clk_en & ~(rd_pend_q & ~rd_done_q);
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_q;
  assign addr_accept = hsel & hready & htrans[1];
  assign wr_fire     = wr_pend_q & hready;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_done_q <= 1'b0;
      addr_q    <= '0;
    end else if (clk_en) begin
      if (addr_accept) begin
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
        rd_done_q <= 1'b0;
        addr_q    <= haddr[`ADDR_W-1:0];
      end else if (hready) begin
        wr_pend_q <= 1'b0;
        rd_pend_q <= 1'b0;
        rd_done_q <= 1'b0;
      end else if (rd_pend_q) begin
        rd_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hrdata_q <= 32'h00000000;
    end else if (clk_en && rd_pend_q && !rd_done_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Settings
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      comp_en_q     <= 1'b0;
      disc_en_q     <= 1'b0;
      adaptor_q     <= alarm_pkg::ADAPT_NONE;
      xfmr_count_q  <= 2'h0;
      ground_res_q  <= `GROUND_RES_MIN;
      winding_res_q <= 24'h000000;
      main_delay_q  <= 13'h0000;
      early_delay_q <= 13'h0000;
      irq_mask_q    <= 4'h0;
    end else if (clk_en && wr_fire) begin
      case (addr_q)
        `REG_CTRL: begin
          comp_en_q <= hwdata[`CTRL_COMP_EN]; // RL2
          disc_en_q <= hwdata[`CTRL_DISC_EN]; // RL14
          if (hwdata[`CTRL_ADAPT_LO+1 -: 2] != 2'b11) begin
            adaptor_q <= alarm_pkg::adaptor_t'(hwdata[`CTRL_ADAPT_LO+1 -: 2]);
          end
          if (hwdata[`CTRL_COUNT_LO+1 -: 2] != 2'h2) begin
            xfmr_count_q <= hwdata[`CTRL_COUNT_LO+1 -: 2]; // RL4
          end
        end
        `REG_GROUND_RES: begin
          ground_res_q <= clamp_res(hwdata, `GROUND_RES_MIN,
                                    `GROUND_RES_MAX); // RL2
        end
        `REG_WINDING_RES: begin
          winding_res_q <= clamp_res(hwdata, 24'h000000,
                                     `WINDING_RES_MAX); // RL3
        end
        `REG_MAIN_DELAY:  main_delay_q  <= clamp_delay(hwdata); // RL12
        `REG_EARLY_DELAY: early_delay_q <= clamp_delay(hwdata); // RL12
        `REG_IRQ_MASK:    irq_mask_q    <= hwdata[`IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Thresholds: reset defaults, then restored once from the store
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      main_thr_q        <= `MAIN_THR_RST; // RL5
      early_thr_q       <= `EARLY_THR_OFF; // RL6
      restore_pending_q <= 1'b1;
    end else if (clk_en) begin
      if (restore_pending_q) begin
        restore_pending_q <= 1'b0;
        if (stored_valid) begin
          main_thr_q  <= clamp_res({8'h00, stored_main_thr},
                                   `MAIN_THR_MIN, `MAIN_THR_MAX); // RL7
          early_thr_q <= (stored_early_thr == `EARLY_THR_OFF) ?
                         `EARLY_THR_OFF :
                         clamp_res({8'h00, stored_early_thr},
                                   `EARLY_THR_MIN, `EARLY_THR_MAX); // RL7
        end
      end else if (wr_fire && addr_q == `REG_MAIN_THR) begin
        main_thr_q <= clamp_res(hwdata, `MAIN_THR_MIN, `MAIN_THR_MAX); // RL5
      end else if (wr_fire && addr_q == `REG_EARLY_THR) begin
        early_thr_q <= (hwdata == 32'h00000000) ? `EARLY_THR_OFF :
                       clamp_res(hwdata, `EARLY_THR_MIN,
                                 `EARLY_THR_MAX); // RL6
      end
    end
  end

  // Store follows every accepted threshold change
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      thr_store_we <= 1'b0;
    end else if (clk_en) begin
      thr_store_we <= ~restore_pending_q & wr_fire &
                      (addr_q == `REG_MAIN_THR || addr_q == `REG_EARLY_THR);
    end
  end
  assign thr_store_main  = main_thr_q;
  assign thr_store_early = early_thr_q;

  // ------------------------------------------------------------
  // Compensation
  // ------------------------------------------------------------
  logic [`RES_W+1:0]  total_winding;
  logic [`RES_W+1:0]  comp_sum;
  logic [`RES_W+1:0]  comp_sub;
  logic [`RES_W-1:0]  comp_res;
  logic               ground_adaptor;

  assign ground_adaptor = (adaptor_q == alarm_pkg::ADAPT_GROUND); // RL19
  assign fault_location_ok = ~ground_adaptor; // RL19
  assign total_winding  = {2'b00, winding_res_q} *
                          {24'h000000, xfmr_count_q}; // RL4

  // Winding resistance sits in series with the ground adaptor path
  always_comb begin
    comp_sum = {2'b00, meas_value} +
               (comp_en_q ? {2'b00, ground_res_q} : 26'h0000000); // RL2
    comp_sub = ground_adaptor ? total_winding : 26'h0000000; // RL3
    if (comp_sum <= comp_sub) begin
      comp_res = 24'h000000;
    end else if ((comp_sum - comp_sub) > 26'h0FFFFFF) begin
      comp_res = 24'hFFFFFF;
    end else begin
      comp_res = 24'(comp_sum - comp_sub);
    end
  end

  // ------------------------------------------------------------
  // Alarm state machines, index 0 main, 1 early
  // ------------------------------------------------------------
  alarm_pkg::alarm_state_t  state_q [2];
  logic [CYC_W-1:0]         cyc_q   [2];
  logic [`DELAY_W-1:0]      sec_q   [2];
  logic [`RES_W-1:0]        thr     [2];
  logic [`DELAY_W-1:0]      dly     [2];
  logic                     armed   [2];

  assign thr[0]   = main_thr_q;
  assign thr[1]   = early_thr_q;
  assign dly[0]   = main_delay_q;
  assign dly[1]   = early_delay_q; // RL13
  assign armed[0] = 1'b1;
  assign armed[1] = (early_thr_q != `EARLY_THR_OFF); // RL6

  for (genvar a = 0; a < 2; a++) begin : g_alarm
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        state_q[a] <= alarm_pkg::ALARM_IDLE;
        cyc_q[a]   <= '0;
        sec_q[a]   <= '0;
      end else if (clk_en) begin
        case (state_q[a])
          alarm_pkg::ALARM_IDLE: begin
            cyc_q[a] <= '0;
            sec_q[a] <= '0;
            if (armed[a] && meas_valid && comp_res < thr[a]) begin // RL1
              state_q[a] <= (dly[a] == 13'h0000) ?
                            alarm_pkg::ALARM_ACTIVE :
                            alarm_pkg::ALARM_COUNT; // RL9
            end
          end
          alarm_pkg::ALARM_COUNT: begin
            if (!armed[a]) begin
              state_q[a] <= alarm_pkg::ALARM_IDLE; // RL13
            end else if (meas_valid && comp_res >= thr[a]) begin
              state_q[a] <= alarm_pkg::ALARM_IDLE; // RL18
            end else if (sec_q[a] >= dly[a]) begin
              state_q[a] <= alarm_pkg::ALARM_ACTIVE; // RL11
            end else if (cyc_q[a] == CYC_W'(TICK_CYCLES - 1)) begin
              cyc_q[a] <= '0;
              sec_q[a] <= sec_q[a] + 13'h0001; // RL11
            end else begin
              cyc_q[a] <= cyc_q[a] + CYC_W'(1);
            end
          end
          alarm_pkg::ALARM_ACTIVE: begin
            if (!armed[a]) begin
              state_q[a] <= alarm_pkg::ALARM_IDLE; // RL6
            end else if (meas_valid && above_hyst(comp_res, thr[a])) begin
              state_q[a] <= alarm_pkg::ALARM_IDLE; // RL10
            end
          end
          default: state_q[a] <= alarm_pkg::ALARM_IDLE;
        endcase
      end
    end
  end

  assign main_alarm  = (state_q[0] == alarm_pkg::ALARM_ACTIVE);
  assign early_alarm = (state_q[1] == alarm_pkg::ALARM_ACTIVE);

  // ------------------------------------------------------------
  // Wiring supervision
  // ------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  logic [2:0]  inj_sync_q;
  logic [2:0]  gnd_sync_q;
  logic [2:0]  link_sync_q;
  logic        inj_open_q;
  logic        gnd_open_q;
  logic        link_open_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      inj_sync_q  <= 3'h0;
      gnd_sync_q  <= 3'h0;
      link_sync_q <= 3'h0;
      inj_open_q  <= 1'b0;
      gnd_open_q  <= 1'b0;
      link_open_q <= 1'b0;
    end else if (clk_en) begin
      inj_sync_q  <= {inj_sync_q[1:0], inj_open_pin};
      gnd_sync_q  <= {gnd_sync_q[1:0], gnd_open_pin};
      link_sync_q <= {link_sync_q[1:0], adaptor_link_pin};
      if (inj_sync_q[1] == inj_sync_q[2]) begin
        inj_open_q <= inj_sync_q[2];
      end
      if (gnd_sync_q[1] == gnd_sync_q[2]) begin
        gnd_open_q <= gnd_sync_q[2];
      end
      if (link_sync_q[1] == link_sync_q[2]) begin
        link_open_q <= link_sync_q[2];
      end
    end
  end

  assign disconnected_injection = disc_en_q &
                                  (inj_open_q | gnd_open_q); // RL14
  assign adaptor_link_broken    = (adaptor_q == alarm_pkg::ADAPT_VOLTAGE) &
                                  link_open_q; // RL15
  assign product_status_led     = disconnected_injection |
                                  adaptor_link_broken; // RL16

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  logic [`IRQ_W-1:0]  evt_now;
  logic [`IRQ_W-1:0]  evt_prev_q;
  logic [`IRQ_W-1:0]  evt_rise;
  logic [`IRQ_W-1:0]  irq_clear;

  assign evt_now = {adaptor_link_broken, disconnected_injection,
                    early_alarm, main_alarm};
  assign evt_rise  = evt_now & ~evt_prev_q;
  assign irq_clear = (wr_fire && addr_q == `REG_IRQ_STATUS) ?
                     hwdata[`IRQ_W-1:0] : 4'h0;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      evt_prev_q   <= 4'h0;
      irq_status_q <= 4'h0;
    end else if (clk_en) begin
      evt_prev_q   <= evt_now;
      // A new event wins over a clear in the same cycle
      irq_status_q <= (irq_status_q & ~irq_clear) | evt_rise; // RL16
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    case (addr_q)
      `REG_CTRL: begin
        rd_mux[`CTRL_COMP_EN]           = comp_en_q;
        rd_mux[`CTRL_DISC_EN]           = disc_en_q;
        rd_mux[`CTRL_ADAPT_LO+1 -: 2]   = adaptor_q;
        rd_mux[`CTRL_COUNT_LO+1 -: 2]   = xfmr_count_q;
      end
      `REG_GROUND_RES:    rd_mux[`RES_W-1:0]   = ground_res_q;
      `REG_WINDING_RES:   rd_mux[`RES_W-1:0]   = winding_res_q;
      `REG_MAIN_THR:      rd_mux[`RES_W-1:0]   = main_thr_q;
      `REG_EARLY_THR:     rd_mux[`RES_W-1:0]   = early_thr_q;
      `REG_MAIN_DELAY:    rd_mux[`DELAY_W-1:0] = main_delay_q;
      `REG_EARLY_DELAY:   rd_mux[`DELAY_W-1:0] = early_delay_q;
      `REG_STATUS: begin
        rd_mux[0] = main_alarm;
        rd_mux[1] = early_alarm;
        rd_mux[2] = (state_q[0] == alarm_pkg::ALARM_COUNT);
        rd_mux[3] = (state_q[1] == alarm_pkg::ALARM_COUNT);
        rd_mux[4] = disconnected_injection;
        rd_mux[5] = adaptor_link_broken;
        rd_mux[6] = product_status_led;
        rd_mux[7] = fault_location_ok;
      end
      `REG_IRQ_STATUS:    rd_mux[`IRQ_W-1:0]   = irq_status_q;
      `REG_IRQ_MASK:      rd_mux[`IRQ_W-1:0]   = irq_mask_q;
      `REG_COMP_RES:      rd_mux[`RES_W-1:0]   = comp_res;
      `REG_TOTAL_WINDING: rd_mux[`RES_W+1:0]   = total_winding;
      default:            rd_mux = 32'h00000000;
    endcase
  end

endmodule

// file: core/insulation_alarm_params.svh
// Offsets, field positions, reset values and timing counts of the evaluator
`ifndef INSULATION_ALARM_PARAMS_SVH
`define INSULATION_ALARM_PARAMS_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define CLK_HZ            25000000
`define TICK_TIME_MS      1000
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_TIME_MS)
`define DELAY_MAX_MIN     120
`define DELAY_MAX_S       13'(`DELAY_MAX_MIN * 60)
`define DELAY_W           13

// ------------------------------------------------------------
// Resistance values, all in ohms
// ------------------------------------------------------------
`define RES_W             24
`define GROUND_RES_MIN    24'h000064
`define GROUND_RES_MAX    24'h07A120
`define WINDING_RES_MAX   24'h00C350
`define MAIN_THR_MIN      24'h000028
`define MAIN_THR_MAX      24'h07A120
`define MAIN_THR_RST      24'h0003E8
`define EARLY_THR_MIN     24'h0003E8
`define EARLY_THR_MAX     24'h0F4240
`define EARLY_THR_OFF     24'h000000

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ADDR_W            6
`define REG_CTRL          6'h00
`define REG_GROUND_RES    6'h04
`define REG_WINDING_RES   6'h08
`define REG_MAIN_THR      6'h0C
`define REG_EARLY_THR     6'h10
`define REG_MAIN_DELAY    6'h14
`define REG_EARLY_DELAY   6'h18
`define REG_STATUS        6'h1C
`define REG_IRQ_STATUS    6'h20
`define REG_IRQ_MASK      6'h24
`define REG_COMP_RES      6'h28
`define REG_TOTAL_WINDING 6'h2C

// ------------------------------------------------------------
// Control register fields and reset value
// ------------------------------------------------------------
`define CTRL_COMP_EN      0
`define CTRL_DISC_EN      1
`define CTRL_ADAPT_LO     2
`define CTRL_COUNT_LO     4
`define CTRL_RST          6'h00

// ------------------------------------------------------------
// Interrupt event bits
// ------------------------------------------------------------
`define IRQ_W             4
`define IRQ_MAIN          0
`define IRQ_EARLY         1
`define IRQ_DISC          2
`define IRQ_ADAPT         3

`endif

// file: tb/front_end_model.sv
// Behavioural measurement front end and threshold store
module front_end_model (
  input  wire logic        mclk,
  input  wire logic        thr_store_we,
  input  wire logic [23:0] thr_store_main,
  input  wire logic [23:0] thr_store_early,
  output logic             meas_valid,
  output logic [23:0]      meas_value,
  output logic             stored_valid,
  output logic [23:0]      stored_main_thr,
  output logic [23:0]      stored_early_thr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    meas_valid = 1'b0;
    meas_value = 24'h000000;
    stored_valid = 1'b1;
    stored_main_thr = 24'h001388;
    stored_early_thr = 24'h004E20;
  end
  // Keep only pairs that respect the ordering, as a careful host would
  always @(posedge mclk) begin
    if (thr_store_we && (thr_store_early == 24'h0 ||
        thr_store_early > thr_store_main)) begin
      stored_main_thr <= thr_store_main;
      stored_early_thr <= thr_store_early;
    end
  end
  task automatic measure(input int v);
    @(posedge mclk);
    meas_value <= 24'(v);
    meas_valid <= 1'b1;
    @(posedge mclk);
    meas_valid <= 1'b0;
    #1;
  endtask
  task automatic forget();
    stored_valid <= 1'b0;
  endtask
endmodule

// file: tb/insulation_alarm_evaluator_chk.sv
// Concurrent checks on the evaluator ports
module alarm_chk (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        meas_valid,
  input wire logic        thr_store_we,
  input wire logic        adaptor_link_pin,
  input wire logic        adaptor_link_broken,
  input wire logic        disconnected_injection,
  input wire logic        product_status_led,
  input wire logic        main_alarm,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  assign take = hsel && hready && htrans[1] && clk_en;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  frozen_bus_a: assert property (!clk_en |-> !hreadyout)
    else $error("ready while frozen");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout)
    |-> $stable(hrdata))
    else $error("read data moved");
  store_pulse_a: assert property (thr_store_we |=> !thr_store_we)
    else $error("store strobe too long");
  main_clear_a: assert property ($fell(main_alarm)
    |-> $past(meas_valid))
    else $error("main alarm cleared without measurement");
  inj_led_a: assert property (disconnected_injection
    |-> product_status_led)
    else $error("status led dark");
  link_sync_a: assert property ($rose(adaptor_link_broken)
    |-> $past(adaptor_link_pin, 2))
    else $error("link flag without pin");
  cover property (take && !hwrite);
  cover property ($rose(main_alarm));
  cover property ($rose(irq));
endmodule
bind insulation_alarm_evaluator alarm_chk chk_u (.*);

// file: tb/insulation_alarm_evaluator_test.sv
// Self-checking bench for the insulation alarm evaluator
`include "insulation_alarm_params.svh"
module insulation_alarm_evaluator_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, reset, clk_en, hsel, hwrite, hreadyout, hresp, irq;
  logic        inj_open_pin, gnd_open_pin, adaptor_link_pin, thr_store_we;
  logic        main_alarm, early_alarm, disconnected_injection;
  logic        adaptor_link_broken, product_status_led, fault_location_ok;
  logic        meas_valid, stored_valid;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [23:0] meas_value, stored_main_thr, stored_early_thr;
  logic [23:0] thr_store_main, thr_store_early;
  wire         hready = hreadyout;
  int          error_cnt, samples_checked, v, c, m, e, n;
  insulation_alarm_evaluator #(.TICK_CYCLES(10)) dut_u (.*);
  front_end_model fe_u (.*);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wt;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      summarize;
    end
  endtask
  task bus(input bit w, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {26'h0, a};
    wt();
    htrans <= 2'b00;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task pause(input int k);
    repeat (k) @(posedge mclk);
  endtask
  initial begin
    v = $urandom(32'h2511);
    {reset, clk_en, hsel, hwrite, inj_open_pin} = 5'b11000;
    {gnd_open_pin, adaptor_link_pin, htrans, hsize} = 7'b0000010;
    haddr = 32'h0;
    hwdata = 32'h0;
    pause(2);
    chk(thr_store_main, 24'h0003E8);
    chk(thr_store_early, `EARLY_THR_OFF);
    reset <= 1'b0;
    rd(`REG_MAIN_THR, 32'd5000);
    rd(`REG_EARLY_THR, 32'd20000);
    rd(`REG_CTRL, 32'h0);
    rd(`REG_MAIN_DELAY, 32'h0);
    rd(6'h30, 32'h0);
    clk_en <= 1'b0;
    pause(3);
    chk(hreadyout, 1'b0);
    clk_en <= 1'b1;
    $display("test reset done");
    wr(`REG_GROUND_RES, 32'd500);
    wr(`REG_CTRL, 32'h1);
    for (int i = 0; i < 40; i++) begin
      v = 3000 + $urandom % (i < 20 ? 4000 : 28000);
      c = v + 500;
      m = c < 5000 ? 1 : (5 * c > 30000 ? 0 : m);
      e = c < 20000 ? 1 : (5 * c > 120000 ? 0 : e);
      fe_u.measure(v);
      chk(main_alarm, m[0]);
      chk(early_alarm, e[0]);
    end
    rd(`REG_COMP_RES, c);
    $display("test hysteresis done");
    fe_u.measure(9000);
    wr(`REG_MAIN_DELAY, 32'd2);
    fe_u.measure(3000);
    pause(10);
    fe_u.measure(9000);
    pause(30);
    chk(main_alarm, 1'b0);
    fe_u.measure(3000);
    n = 0;
    while (main_alarm !== 1'b1 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    chk(n >= 18 && n <= 23, 1'b1);
    wr(`REG_MAIN_DELAY, 32'd0);
    $display("test delay done");
    wr(`REG_WINDING_RES, 32'd60000);
    rd(`REG_WINDING_RES, 32'd50000);
    wr(`REG_CTRL, 32'h39);
    wr(`REG_CTRL, 32'h29);
    rd(`REG_CTRL, 32'h39);
    rd(`REG_TOTAL_WINDING, 32'd150000);
    chk(fault_location_ok, 1'b0);
    fe_u.measure(200000);
    rd(`REG_COMP_RES, 32'd50500);
    wr(`REG_CTRL, 32'h19);
    rd(`REG_TOTAL_WINDING, 32'd50000);
    wr(`REG_CTRL, 32'h09);
    rd(`REG_TOTAL_WINDING, 32'd0);
    wr(`REG_CTRL, 32'h1);
    {inj_open_pin, gnd_open_pin} <= 2'h1 << $urandom % 2;
    pause(10);
    chk(disconnected_injection, 1'b0);
    chk(fault_location_ok, 1'b1);
    wr(`REG_CTRL, 32'h3);
    pause(10);
    chk(disconnected_injection, 1'b1);
    chk(product_status_led, 1'b1);
    wr(`REG_CTRL, 32'h5);
    adaptor_link_pin <= 1'b1;
    pause(10);
    chk(adaptor_link_broken, 1'b1);
    {inj_open_pin, gnd_open_pin, adaptor_link_pin} <= 3'h0;
    pause(10);
    $display("test wiring done");
    wr(`REG_IRQ_MASK, 32'h0);
    pause(2);
    chk(irq, 1'b0);
    rd(`REG_IRQ_STATUS, 32'hF);
    wr(`REG_IRQ_MASK, 32'hF);
    pause(2);
    chk(irq, 1'b1);
    wr(`REG_IRQ_STATUS, 32'hF);
    pause(2);
    chk(irq, 1'b0);
    rd(`REG_IRQ_STATUS, 32'h0);
    wr(`REG_EARLY_DELAY, 32'd5);
    wr(`REG_EARLY_THR, 32'd0);
    fe_u.measure(3000);
    chk(early_alarm, 1'b0);
    chk(main_alarm, 1'b1);
    $display("test irq and early off done");
    fe_u.forget();
    reset <= 1'b1;
    pause(2);
    reset <= 1'b0;
    rd(`REG_MAIN_THR, 32'h000003E8);
    rd(`REG_EARLY_THR, 32'h00000000);
    $display("test second reset done");
    summarize;
  end
endmodule
